// ### core/device_serial_rom_bank.v
// Contract
// - The bank presents a 96-bit identifier unique to each device.
// - Writes to identifier locations never change any stored bit.
// - Software fetches each byte with its own read and joins them itself.
// - Bytes lie LSB first over twelve addresses: X, Y, wafer, then lot.
`timescale 1ns/1ps
`default_nettype none
`include "serial_rom_map.vh"

// Read-only identifier bank on the peripheral register port
//
// Address map, least significant byte first:
//   0x4926 die X low        0x492c serial byte 6
//   0x4927 die X high       0x492d serial byte 7
//   0x4928 die Y low        0x492e lot code byte 8
//   0x4929 die Y high       0x492f lot code byte 9
//   0x492a wafer index      0x4930 lot code byte 10
//   0x492b serial byte 5    0x4931 lot code byte 11
//
// Behaviour:
//   A mapped read loads its byte into the output register, and the
//   byte stands for exactly the one cycle after the strobe.
//   Every other cycle, reset included, loads zero, so a late sample
//   of the port never picks up stale identifier bits.
//   Writes are taken and dropped; no path leads from wdata to storage.
//
// Timing:
//   edge n     read strobe and address sampled, byte loaded
//   cycle n+1  byte stands on rdata
//   edge n+1   zero loaded unless another read follows
//   Back-to-back reads give back-to-back bytes with no idle cycle.
//
// Reset:
//   Reset touches no identifier bit; it only holds reads off, so the
//   output register loads zero for as long as reset is high.
//   The first read may follow in the cycle after release.
//
// Decode:
//   Three decoders look at the address: a subtracting window compare,
//   a table of the twelve locations and a one-hot select vector.
//   A read reaches the table only when both index paths agree and exactly one select line is set, so a single
//   decode fault returns zero instead of a plausible wrong byte.
//   The cost is a few dozen gates; the bank is never timing critical.
//
// Limitation: there is no error response, so a write here looks to
// software exactly like a successful write anywhere else.
module device_serial_rom_bank (
	input  wire                 ref_clk,
	input  wire                 srst,
	input  wire [`ADDR_W-1:0]   addr,
	input  wire [`DATA_W-1:0]   wdata,
	input  wire                 wr_stb,
	input  wire                 rd_stb,
	output wire [`DATA_W-1:0]   rdata
);
	// Die X position, low byte
	// First location of the bank
	localparam [`ADDR_W-1:0] LOC_DIE_X_LOW  = `ADDR_DIE_X_LOW;

	// Die X position, high byte
	// Joined above the low byte by software
	localparam [`ADDR_W-1:0] LOC_DIE_X_HIGH = `ADDR_DIE_X_HIGH;

	// Die Y position, low byte
	// Starts the second field
	localparam [`ADDR_W-1:0] LOC_DIE_Y_LOW  = `ADDR_DIE_Y_LOW;

	// Die Y position, high byte
	// Ends the position fields
	localparam [`ADDR_W-1:0] LOC_DIE_Y_HIGH = `ADDR_DIE_Y_HIGH;

	// Wafer index
	// Single byte of the wafer field
	localparam [`ADDR_W-1:0] LOC_WAFER      = `ADDR_WAFER;

	// Serial byte 5
	// Upper bytes follow without a gap
	localparam [`ADDR_W-1:0] LOC_SERIAL_5   = `ADDR_SERIAL_5;

	// Serial byte 6
	// Middle of the upper serial part
	localparam [`ADDR_W-1:0] LOC_SERIAL_6   = `ADDR_SERIAL_6;

	// Serial byte 7
	// Last byte before the lot code
	localparam [`ADDR_W-1:0] LOC_SERIAL_7   = `ADDR_SERIAL_7;

	// Lot code byte 8
	// Lowest byte of the lot code
	localparam [`ADDR_W-1:0] LOC_LOT_8      = `ADDR_LOT_8;

	// Lot code byte 9
	// Second lot code byte
	localparam [`ADDR_W-1:0] LOC_LOT_9      = `ADDR_LOT_9;

	// Lot code byte 10
	// Third lot code byte
	localparam [`ADDR_W-1:0] LOC_LOT_10     = `ADDR_LOT_10;

	// Lot code byte 11
	// Last location of the bank
	localparam [`ADDR_W-1:0] LOC_LOT_LAST   = `ADDR_LOT_LAST;

	// True for the twelve identifier addresses, written out one by one so
	// that it shares no arithmetic with the subtracting decoder
	function is_id_location;
		input [`ADDR_W-1:0] a;
		begin
			case (a)
				// Die X low
				LOC_DIE_X_LOW: begin
					is_id_location = 1'b1;
				end
				// Die X high
				LOC_DIE_X_HIGH: begin
					is_id_location = 1'b1;
				end
				// Die Y low
				LOC_DIE_Y_LOW: begin
					is_id_location = 1'b1;
				end
				// Die Y high
				LOC_DIE_Y_HIGH: begin
					is_id_location = 1'b1;
				end
				// Wafer
				LOC_WAFER: begin
					is_id_location = 1'b1;
				end
				// Serial byte 5
				LOC_SERIAL_5: begin
					is_id_location = 1'b1;
				end
				// Serial byte 6
				LOC_SERIAL_6: begin
					is_id_location = 1'b1;
				end
				// Serial byte 7
				LOC_SERIAL_7: begin
					is_id_location = 1'b1;
				end
				// Lot byte 8
				LOC_LOT_8: begin
					is_id_location = 1'b1;
				end
				// Lot byte 9
				LOC_LOT_9: begin
					is_id_location = 1'b1;
				end
				// Lot byte 10
				LOC_LOT_10: begin
					is_id_location = 1'b1;
				end
				// Lot byte 11
				LOC_LOT_LAST: begin
					is_id_location = 1'b1;
				end
				default: begin
					is_id_location = 1'b0;
				end
			endcase
		end
	endfunction

	// Byte index of a location, from the table rather than by subtraction;
	// unmapped addresses give index zero, which the hit terms then mask
	function [`ID_IDX_W-1:0] id_location_index;
		input [`ADDR_W-1:0] a;
		begin
			case (a)
				// Die X low
				LOC_DIE_X_LOW: begin
					id_location_index = `IDX_DIE_X_LOW;
				end
				// Die X high
				LOC_DIE_X_HIGH: begin
					id_location_index = `IDX_DIE_X_HIGH;
				end
				// Die Y low
				LOC_DIE_Y_LOW: begin
					id_location_index = `IDX_DIE_Y_LOW;
				end
				// Die Y high
				LOC_DIE_Y_HIGH: begin
					id_location_index = `IDX_DIE_Y_HIGH;
				end
				// Wafer
				LOC_WAFER: begin
					id_location_index = `IDX_WAFER;
				end
				// Serial byte 5
				LOC_SERIAL_5: begin
					id_location_index = `IDX_SERIAL_5;
				end
				// Serial byte 6
				LOC_SERIAL_6: begin
					id_location_index = `IDX_SERIAL_6;
				end
				// Serial byte 7
				LOC_SERIAL_7: begin
					id_location_index = `IDX_SERIAL_7;
				end
				// Lot byte 8
				LOC_LOT_8: begin
					id_location_index = `IDX_LOT_8;
				end
				// Lot byte 9
				LOC_LOT_9: begin
					id_location_index = `IDX_LOT_9;
				end
				// Lot byte 10
				LOC_LOT_10: begin
					id_location_index = `IDX_LOT_10;
				end
				// Lot byte 11
				LOC_LOT_LAST: begin
					id_location_index = `IDX_LOT_LAST;
				end
				default: begin
					id_location_index = `IDX_DIE_X_LOW;
				end
			endcase
		end
	endfunction

	// Counts set select lines; exactly one may be set on a mapped address
	function [`ID_IDX_W:0] count_selects;
		input [`ID_BYTES-1:0] v;
		integer i;
		begin
			count_selects = {(`ID_IDX_W+1){1'b0}};
			for (i = 0; i < `ID_BYTES; i = i + 1) begin
				count_selects = count_selects + v[i];
			end
		end
	endfunction

	// Decode results and the gated read enable
	wire                 hit;
	wire [`ID_IDX_W-1:0] index;
	wire [`DATA_W-1:0]   rom_data;
	wire                 table_hit;
	wire [`ID_IDX_W-1:0] table_index;
	wire [`ID_BYTES-1:0] sel;
	wire                 sel_single;
	wire                 index_agree;
	wire                 rd_take;

	// One-hot select vector, one compare per location
	// Die X
	assign sel[`IDX_DIE_X_LOW]  = (addr == LOC_DIE_X_LOW);
	// Die X high
	assign sel[`IDX_DIE_X_HIGH] = (addr == LOC_DIE_X_HIGH);
	// Die Y
	assign sel[`IDX_DIE_Y_LOW]  = (addr == LOC_DIE_Y_LOW);
	// Die Y high
	assign sel[`IDX_DIE_Y_HIGH] = (addr == LOC_DIE_Y_HIGH);
	// Wafer
	assign sel[`IDX_WAFER]      = (addr == LOC_WAFER);
	// Serial byte 5
	assign sel[`IDX_SERIAL_5]   = (addr == LOC_SERIAL_5);
	// Serial byte 6
	assign sel[`IDX_SERIAL_6]   = (addr == LOC_SERIAL_6);
	// Serial byte 7
	assign sel[`IDX_SERIAL_7]   = (addr == LOC_SERIAL_7);
	// Lot byte 8
	assign sel[`IDX_LOT_8]      = (addr == LOC_LOT_8);
	// Lot byte 9
	assign sel[`IDX_LOT_9]      = (addr == LOC_LOT_9);
	// Lot byte 10
	assign sel[`IDX_LOT_10]     = (addr == LOC_LOT_10);
	// Lot byte 11
	assign sel[`IDX_LOT_LAST]   = (addr == LOC_LOT_LAST);

	// Window decoder: one subtract and one compare
	serial_addr_decode u_decode (
		.addr  (addr),
		.hit   (hit),
		.index (index)
	);

	// Table decoder, an independent second opinion
	assign table_hit   = is_id_location(addr);
	assign table_index = id_location_index(addr);
	// Exactly one select line may be set
	assign sel_single  = (count_selects(sel) == {{`ID_IDX_W{1'b0}}, 1'b1});
	// Both index paths must name the same byte
	assign index_agree = (index == table_index);
	// Reads are held off during reset; the table itself never resets
	assign rd_take     = rd_stb & hit & table_hit & sel_single & index_agree & ~srst;

	// No write port exists, so wr_stb and wdata cannot reach any bit
	serial_byte_rom u_rom (
		.ref_clk (ref_clk),
		.rd_en   (rd_take),
		.index   (index),
		.rd_data (rom_data)
	);

	// Straight from the table's output register: zero unless a read hit
	assign rdata = rom_data;
endmodule // device_serial_rom_bank
`default_nettype wire

// ### core/serial_addr_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "serial_rom_map.vh"

// Maps a bus address onto an identifier byte index
module serial_addr_decode (
	input  wire [`ADDR_W-1:0]   addr,
	output wire                 hit,
	output wire [`ID_IDX_W-1:0] index
);
	wire [`ADDR_W-1:0] offset;

	// Subtraction wraps below the base, so one compare covers both ends
	assign offset = addr - `ADDR_DIE_X_LOW;
	assign hit    = (offset < `ID_BYTES);
	assign index  = offset[`ID_IDX_W-1:0];
endmodule // serial_addr_decode
`default_nettype wire

// ### core/serial_byte_rom.v
`timescale 1ns/1ps
`default_nettype none
`include "serial_rom_map.vh"

// Fixed byte table with a registered read port and no write port
module serial_byte_rom (
	input  wire                 ref_clk,
	input  wire                 rd_en,
	input  wire [`ID_IDX_W-1:0] index,
	output reg  [`DATA_W-1:0]   rd_data
);
	wire [`ID_BITS-1:0] device_serial_bits;

	// Least significant byte first: X, Y, wafer, then lot
	assign device_serial_bits = {`ID_LOT, `ID_WAFER, `ID_DIE_Y, `ID_DIE_X};

	// Zero outside reads, so a byte stands for one cycle only
	always @(posedge ref_clk) begin
		if (rd_en) begin
			rd_data <= device_serial_bits[index*`DATA_W +: `DATA_W];
		end else begin
			rd_data <= `READ_UNMAPPED;
		end
	end
endmodule // serial_byte_rom
`default_nettype wire

// ### core/serial_rom_map.vh
`ifndef SERIAL_ROM_MAP_VH
`define SERIAL_ROM_MAP_VH

// Address and data widths of the register port
`define ADDR_W            16
`define DATA_W            8
// Number of identifier bytes and index width
`define ID_BYTES          12
`define ID_IDX_W          4
`define ID_BITS           96
// Byte addresses of the identifier locations
`define ADDR_DIE_X_LOW    16'h4926
`define ADDR_DIE_X_HIGH   16'h4927
`define ADDR_DIE_Y_LOW    16'h4928
`define ADDR_DIE_Y_HIGH   16'h4929
`define ADDR_WAFER        16'h492a
`define ADDR_SERIAL_5     16'h492b
`define ADDR_SERIAL_6     16'h492c
`define ADDR_SERIAL_7     16'h492d
`define ADDR_LOT_8        16'h492e
`define ADDR_LOT_9        16'h492f
`define ADDR_LOT_10       16'h4930
`define ADDR_LOT_LAST     16'h4931
// Byte index of each location inside the identifier
`define IDX_DIE_X_LOW     4'h0
`define IDX_DIE_X_HIGH    4'h1
`define IDX_DIE_Y_LOW     4'h2
`define IDX_DIE_Y_HIGH    4'h3
`define IDX_WAFER         4'h4
`define IDX_SERIAL_5      4'h5
`define IDX_SERIAL_6      4'h6
`define IDX_SERIAL_7      4'h7
`define IDX_LOT_8         4'h8
`define IDX_LOT_9         4'h9
`define IDX_LOT_10        4'ha
`define IDX_LOT_LAST      4'hb
// Value returned for an unmapped address
`define READ_UNMAPPED     8'h00
// Neutral identifier value per field (arbitrary, replace per die at build)
`define ID_DIE_X          16'h0001
`define ID_DIE_Y          16'h0002
`define ID_WAFER          8'h03
`define ID_LOT            56'h00000000000004

`endif

// ### verif/device_serial_rom_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_rom_map.vh"
module device_serial_rom_bank_bench;
logic ref_clk=0,srst=1,wr_stb=0,rd_stb=0;logic [15:0] addr=0;logic [7:0] wdata=0,rdata;
logic [95:0] c;int n_mismatch=0,num_checks=0,a;bit w;
localparam logic [95:0] ID={`ID_LOT,`ID_WAFER,`ID_DIE_Y,`ID_DIE_X};
device_serial_rom_bank u_device_serial_rom_bank(.*);
function logic [7:0] exp_byte(int a);int o;o=a-`ADDR_DIE_X_LOW;
return (o>=0&&o<`ID_BYTES)?ID[8*o+:8]:`READ_UNMAPPED;endfunction
task cmp(logic [95:0] g,x);num_checks++;if(g!==x)begin n_mismatch++;
$display("BAD %0t identifier mismatch",$time);end endtask
task cmp_b(logic [7:0] g,x);num_checks++;if(g!==x)begin n_mismatch++;
$display("BAD %0t byte mismatch",$time);end endtask
task op(bit w,int a);@(posedge ref_clk);{wr_stb,rd_stb,addr,wdata}<={w,!w,a[15:0],8'($urandom)};
@(posedge ref_clk);{wr_stb,rd_stb}<=0;#1;endtask
task end_sim;if(!n_mismatch&&num_checks)$display("verification passed");
else $display("verification failed");$finish;endtask
always #2.5 ref_clk=~ref_clk;
initial begin void'($urandom(80829));repeat(4)@(posedge ref_clk);
repeat(2)begin @(posedge ref_clk) srst<=0;
for(int i=0;i<12;i++)begin op(0,`ADDR_DIE_X_LOW+i);
cmp_b(rdata,exp_byte(`ADDR_DIE_X_LOW+i));
c={rdata,c[95:8]};end
cmp(c,ID);
for(int i=0;i<12;i++)op(1,`ADDR_DIE_X_LOW+i);
@(posedge ref_clk);{rd_stb,addr}<={1'b1,16'(`ADDR_WAFER)};@(posedge ref_clk);
@(posedge ref_clk);rd_stb<=0;#1;
cmp_b(rdata,exp_byte(`ADDR_WAFER));
repeat(99)begin a=`ADDR_DIE_X_LOW-6+$urandom%24;w=$urandom;op(w,a);
if(!w)cmp_b(rdata,exp_byte(a));
@(posedge ref_clk);#1;
cmp_b(rdata,`READ_UNMAPPED);
end
@(posedge ref_clk);srst<=1;@(posedge ref_clk);#1;
cmp_b(rdata,`READ_UNMAPPED);
end
end_sim;end
endmodule // device_serial_rom_bank_bench
`default_nettype wire

// ### verif/rom_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_rom_map.vh"
module rom_chk(input wire ref_clk,srst,rd_stb,wr_stb,input wire [15:0] addr,
input wire [7:0] rdata);
localparam [95:0] id={`ID_LOT,`ID_WAFER,`ID_DIE_Y,`ID_DIE_X};
wire h=(addr-`ADDR_DIE_X_LOW)<`ID_BYTES;
default clocking @(posedge ref_clk);endclocking
default disable iff(srst);
property p_m;rd_stb&&h|=>rdata==id[8*($past(addr)-`ADDR_DIE_X_LOW)+:8];endproperty
a_m:assert property(p_m)else $error("read byte wrong");
property p_z;!(rd_stb&&h)|=>rdata==8'h00;endproperty
a_z:assert property(p_z)else $error("byte not zero");
property p_rst;disable iff(1'b0) srst|=>rdata==8'h00;endproperty
a_rst:assert property(p_rst)else $error("byte during reset");
property p_w;wr_stb|=>rdata==8'h00;endproperty
a_w:assert property(p_w)else $error("write gave data");
property p_rpt;rd_stb&&h&&$past(rd_stb&&h)&&addr==$past(addr)|=>rdata==$past(rdata);endproperty
a_rpt:assert property(p_rpt)else $error("repeat read differs");
cover property(rd_stb&&h);
cover property(rd_stb&&h&&$past(rd_stb&&h));
cover property(rd_stb&&!h);
cover property($fell(srst));
endmodule // rom_chk
bind device_serial_rom_bank rom_chk u_rom_chk(.*);
`default_nettype wire
